// ---- hmou_hart_model.sv ----
// Purpose: Other hart writing into the shared memory seen by the ordering unit
// Assumes: One write per request, presented the cycle after the request edge
// Notes: Idle cycles flip the data so a stale write can never pass for a real one
`timescale 1ns/100ps
module hmou_hart_model import hmou_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic req,
   input wire logic [15:0] mask,
   input wire logic [127:0] data,
   output hmou_ext_s ext
);
   always @(posedge clk) begin
      if (!rstn) begin
         ext <= '0;
      end else if (req) begin
         ext <= '{valid: 1'b1, mask: mask, data: data};
      end else begin
         ext.valid <= 1'b0;
         ext.data <= ~ext.data;
      end
   end
endmodule : hmou_hart_model

// ---- hmou_pkg.sv ----
// Purpose: Constants and types for the hart memory ordering unit
// Assumes: Four program-ordered entries, sixteen bytes of shared memory
// Notes: Entry index is program order, entry zero oldest
// Function
// - Satisfy a load from memory only under forwarding ordering, all open slices at once.
// - No load takes data while an older unfinished acquire load is unsatisfied.
// - A load completes when fully satisfied; value built from satisfying bytes.
// - Unpaired store-conditional fails early with a false result.
// - Aligned store is one operation; misaligned store is one operation per byte.
// - Store footprint is published before its data is known.
// - Store data is split over its operations, then awaits propagation.
// - Commit needs determined data and finished older branches and indirect jumps.
// - Commit waits for older write-ordering fences and store-order fences.
// - Commit waits for older acquire loads, acquire-release stores; release waits all.
// - Commit waits until every older access has a known footprint.
// - Propagate only after older overlapping store operations propagated.
// - Propagate only after older overlapping loads satisfied and non-restartable.
// - Propagate only after loads fed by forwarding from it are satisfied.
// - Non-restartable means no pending propagation or satisfaction can restart it.
// - Propagation writes memory and restarts younger loads that read overlapping stale bytes.
// - A restarted instruction also restarts its dependents, recursively.
// - Successful store-conditional commits and propagates at once after its reserve finished.
// - Store-conditional succeeds only if no other hart overwrote its reserved bytes; a write in the cycle of the reserve read or of its propagation is missed.
// - Store-conditional carries one operation and meets normal commit and propagate rules.
// - Unpropagated store-conditional may fail any time, dropping its operations.
// - Store completes true once all its operations propagated.
package hmou_pkg;
   localparam int NE = 4;
   localparam int MB = 16;
   localparam logic [1:0] K_LD = 2'h0;
   localparam logic [1:0] K_ST = 2'h1;
   localparam logic [1:0] K_OTH = 2'h2;

   typedef enum logic [2:0] {OP_NOP, OP_ALLOC, OP_FOOT, OP_DATA, OP_FINISH, OP_FREE, OP_SCFAIL} hmou_op_e;

   typedef struct packed {
      hmou_op_e op;
      logic [1:0] idx;
      logic [1:0] kind;
      logic acq;
      logic rel;
      logic res;
      logic brn;
      logic fsw;
      logic ftso;
      logic pv;
      logic [1:0] pair;
      logic [3:0] addr;
      logic [1:0] size;
      logic [63:0] data;
   } hmou_cmd_s;

   typedef struct packed {
      logic valid;
      logic [15:0] mask;
      logic [127:0] data;
   } hmou_ext_s;

   typedef struct packed {
      logic [1:0] idx;
      logic is_st;
      logic ok;
      logic [63:0] data;
   } hmou_comp_s;

   typedef struct packed {
      logic v;
      logic [1:0] kind;
      logic acq;
      logic rel;
      logic res;
      logic brn;
      logic fsw;
      logic ftso;
      logic pv;
      logic [1:0] pair;
      logic [3:0] addr;
      logic split;
      logic fpk;
      logic [15:0] fp;
      logic dk;
      logic cm;
      logic [15:0] prop;
      logic [15:0] sat;
      logic done;
      logic fin;
      logic scf;
      logic lost;
      logic [127:0] bd;
   } hmou_ent_s;

   localparam hmou_ent_s ENT_RST = '0;
   localparam hmou_comp_s COMP_RST = '0;
   localparam logic [127:0] MEM_RST = '0;
endpackage : hmou_pkg

// ---- hmou_top.sv ----
// Purpose: Per-hart load satisfaction, store commit and propagation ordering
// Assumes: Entry index is program order; an index is reused only when all younger ones are free
// Notes: No forwarding path; restart is conservative, covering every younger unfinished entry
`timescale 1ns/100ps
module hmou_top import hmou_pkg::*; (
   input logic CLK,
   input logic RSTN,
   input logic CMD_VALID,
   input hmou_cmd_s CMD,
   input hmou_ext_s EXT,
   output logic COMP_VALID,
   output hmou_comp_s COMP,
   output logic [NE-1:0] RESTART
);
   hmou_ent_s ent [NE];
   hmou_ent_s next_ent [NE];
   logic [127:0] mem;
   logic [127:0] next_mem;
   logic next_comp_valid;
   hmou_comp_s next_comp;
   logic [NE-1:0] next_restart;
   logic ld_ok [NE];
   logic cm_ok [NE];
   logic nr [NE];
   logic [15:0] blk [NE];
   logic [15:0] pb [NE];
   logic [NE-1:0] sat_go;
   logic [NE-1:0] cm_go;
   logic [NE-1:0] sc_go;
   logic [NE-1:0] rs;
   logic [NE-1:0] cand;

   function automatic logic [15:0] fp_mask(input logic [3:0] a, input logic [1:0] s);
      logic [15:0] m;
      m = 16'((16'h1 << (4'h1 << s)) - 16'h1);
      return 16'(m << a);
   endfunction : fp_mask

   for (genvar i = 0; i < NE; i++) begin : g_ent
      always_comb begin
         ld_ok[i] = 1'b1;
         cm_ok[i] = 1'b1;
         blk[i] = 16'h0;
         nr[i] = 1'b1;
         for (int j = 0; j < i; j++) begin
            if (ent[j].v) begin
               // A load with no footprint yet counts as unsatisfied
               if (ent[j].kind == K_LD && ent[j].acq && !ent[j].fin && (ent[j].sat != ent[j].fp || !ent[j].fpk)) begin
                  ld_ok[i] = 1'b0;
               end
               if (!ent[j].fin && ((ent[i].acq && ent[j].kind == K_ST && ent[j].rel) ||
                   (ent[i].acq && ent[i].rel) || (ent[j].kind == K_ST && ent[j].acq && ent[j].rel))) begin
                  ld_ok[i] = 1'b0;
               end
               if (ent[j].ftso && !ent[j].fin) begin
                  for (int k = 0; k < j; k++) begin
                     if (ent[k].v && ent[k].kind == K_LD && (ent[k].sat != ent[k].fp || !ent[k].fpk)) begin
                        ld_ok[i] = 1'b0;
                     end
                  end
               end
               if (!ent[j].fin && (ent[j].brn || ent[i].rel)) begin
                  cm_ok[i] = 1'b0;
               end
               if (!ent[j].fin && (ent[j].fsw || ent[j].ftso)) begin
                  cm_ok[i] = 1'b0;
               end
               if (!ent[j].fin && ((ent[j].kind == K_LD && ent[j].acq) ||
                   (ent[j].kind == K_ST && ent[j].acq && ent[j].rel))) begin
                  cm_ok[i] = 1'b0;
               end
               if (ent[j].kind != K_OTH && !ent[j].fpk && !ent[j].scf) begin
                  cm_ok[i] = 1'b0;
               end
               // Footprint alone blocks, data need not be known yet
               if (ent[j].kind == K_ST && !ent[j].scf) begin
                  blk[i] = blk[i] | (ent[j].fp & ~ent[j].prop);
               end
               if (ent[j].kind == K_LD && (ent[j].fp & ent[i].fp) != 16'h0 &&
                   (ent[j].sat != ent[j].fp || !nr[j] || !ent[j].fpk)) begin
                  blk[i] = blk[i] | ent[j].fp;
               end
               // Only older stores can restart a load here, since nothing is forwarded
               if (ent[j].kind == K_ST && !ent[j].scf &&
                   (!ent[j].fpk || (ent[j].fp & ~ent[j].prop & ent[i].fp) != 16'h0)) begin
                  nr[i] = 1'b0;
               end
            end
         end
      end

      assign sat_go[i] = ent[i].v && ent[i].kind == K_LD && ent[i].fpk && ent[i].sat != ent[i].fp &&
                         ld_ok[i];
      assign cm_go[i] = ent[i].v && ent[i].kind == K_ST && !ent[i].res && ent[i].fpk && ent[i].dk &&
                        !ent[i].cm && cm_ok[i];
      // Store-conditional must be a single aligned operation with an intact, finished reserve
      assign sc_go[i] = ent[i].v && ent[i].kind == K_ST && ent[i].res && ent[i].pv && ent[i].fpk &&
                        ent[i].dk && !ent[i].cm && !ent[i].scf && !ent[i].split && cm_ok[i] &&
                        ent[ent[i].pair].fin && !ent[ent[i].pair].lost &&
                        (blk[i] & ent[i].fp) == 16'h0;

      always_comb begin
         pb[i] = 16'h0;
         if (sc_go[i]) begin
            pb[i] = ent[i].fp;
         end else if (ent[i].v && ent[i].cm && !ent[i].res) begin
            // No forwarding exists, so no load waits on this store's forwarded data
            if (ent[i].split) begin
               pb[i] = ent[i].fp & ~ent[i].prop & ~blk[i];
            end else if ((ent[i].fp & ~ent[i].prop & blk[i]) == 16'h0) begin
               pb[i] = ent[i].fp & ~ent[i].prop;
            end
         end
      end

      always_comb begin
         rs[i] = 1'b0;
         for (int j = 0; j < i; j++) begin
            if (ent[i].v && !ent[i].fin && ent[i].kind == K_LD &&
                (pb[j] & (ent[i].sat | (sat_go[i] ? ent[i].fp : 16'h0))) != 16'h0) begin
               rs[i] = 1'b1;
            end
         end
      end

      // Dependents are not tracked, so any restarted older entry restarts every younger unfinished one
      assign next_restart[i] = ent[i].v && !ent[i].fin &&
                               (rs & NE'((1 << (i + 1)) - 1)) != '0;
      assign cand[i] = ent[i].v && !ent[i].done && !next_restart[i] &&
                       ((ent[i].kind == K_LD && ent[i].fpk && ent[i].sat == ent[i].fp) ||
                        (ent[i].kind == K_ST && (ent[i].scf || (ent[i].fpk && ent[i].cm &&
                         ent[i].prop == ent[i].fp))));
   end

   always_comb begin
      logic pick;
      pick = 1'b0;
      next_mem = mem;
      next_comp_valid = 1'b0;
      next_comp = COMP;
      for (int i = 0; i < NE; i++) begin
         next_ent[i] = ent[i];
      end
      for (int b = 0; b < MB; b++) begin
         if (EXT.valid && EXT.mask[b]) begin
            next_mem[b*8 +: 8] = EXT.data[b*8 +: 8];
         end
      end
      for (int i = 0; i < NE; i++) begin
         if (ent[i].kind == K_LD && ent[i].res && EXT.valid && (EXT.mask & ent[i].sat) != 16'h0) begin
            next_ent[i].lost = 1'b1;
         end
         for (int b = 0; b < MB; b++) begin
            if (pb[i][b]) begin
               next_mem[b*8 +: 8] = ent[i].bd[b*8 +: 8];
            end
            if (sat_go[i] && !ent[i].sat[b] && ent[i].fp[b]) begin
               next_ent[i].bd[b*8 +: 8] = mem[b*8 +: 8];
            end
         end
         if (sat_go[i]) begin
            next_ent[i].sat = ent[i].fp;
         end
         next_ent[i].prop = ent[i].prop | pb[i];
         if (cm_go[i] || sc_go[i]) begin
            next_ent[i].cm = 1'b1;
         end
         if (cand[i] && !pick) begin
            pick = 1'b1;
            next_ent[i].done = 1'b1;
            next_comp_valid = 1'b1;
            next_comp.idx = 2'(i);
            next_comp.is_st = ent[i].kind == K_ST;
            next_comp.ok = ent[i].kind == K_ST && !ent[i].scf;
            next_comp.data = ent[i].kind == K_LD ? 64'(ent[i].bd >> {ent[i].addr, 3'h0}) : 64'h0;
         end
         if (next_restart[i]) begin
            next_ent[i].sat = 16'h0;
            next_ent[i].done = 1'b0;
         end
      end
      if (CMD_VALID) begin
         case (CMD.op)
            OP_ALLOC: begin
               next_ent[CMD.idx] = ENT_RST;
               next_ent[CMD.idx].v = 1'b1;
               next_ent[CMD.idx].kind = CMD.kind;
               next_ent[CMD.idx].acq = CMD.acq;
               next_ent[CMD.idx].rel = CMD.rel;
               next_ent[CMD.idx].res = CMD.res;
               next_ent[CMD.idx].brn = CMD.brn;
               next_ent[CMD.idx].fsw = CMD.fsw;
               next_ent[CMD.idx].ftso = CMD.ftso;
               next_ent[CMD.idx].pv = CMD.pv;
               next_ent[CMD.idx].pair = CMD.pair;
               // conditional_store_pairing_check
               next_ent[CMD.idx].scf = CMD.kind == K_ST && CMD.res && !CMD.pv;
            end
            OP_FOOT: begin
               next_ent[CMD.idx].fpk = 1'b1;
               next_ent[CMD.idx].addr = CMD.addr;
               next_ent[CMD.idx].fp = ent[CMD.idx].scf ? 16'h0 : fp_mask(CMD.addr, CMD.size);
               next_ent[CMD.idx].split = (CMD.addr & 4'((4'h1 << CMD.size) - 4'h1)) != 4'h0;
            end
            OP_DATA: begin
               next_ent[CMD.idx].dk = 1'b1;
               next_ent[CMD.idx].bd = 128'({64'h0, CMD.data} << {ent[CMD.idx].addr, 3'h0});
            end
            OP_FINISH: begin
               next_ent[CMD.idx].fin = 1'b1;
            end
            OP_FREE: begin
               next_ent[CMD.idx] = ENT_RST;
            end
            OP_SCFAIL: begin
               // A reserve load shares the res bit, so only a store may be failed here
               if (ent[CMD.idx].kind == K_ST && ent[CMD.idx].res && ent[CMD.idx].prop == 16'h0 &&
                   !sc_go[CMD.idx]) begin
                  next_ent[CMD.idx].scf = 1'b1;
                  next_ent[CMD.idx].fp = 16'h0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         for (int i = 0; i < NE; i++) begin
            ent[i] <= ENT_RST;
         end
         mem <= MEM_RST;
         COMP_VALID <= 1'b0;
         COMP <= COMP_RST;
         RESTART <= '0;
      end else begin
         for (int i = 0; i < NE; i++) begin
            ent[i] <= next_ent[i];
         end
         mem <= next_mem;
         COMP_VALID <= next_comp_valid;
         COMP <= next_comp;
         RESTART <= next_restart;
      end
   end

   for (genvar i = 0; i < NE; i++) begin : g_chk
      a_load_whole: assert property (@(posedge CLK) disable iff (!RSTN)
         sat_go[i] && !next_restart[i] && !(CMD_VALID && CMD.idx == 2'(i)) |=> ent[i].sat == ent[i].fp)
         else $error("load not satisfied whole");
      a_comp_load: assert property (@(posedge CLK) disable iff (!RSTN)
         COMP_VALID && !COMP.is_st && COMP.idx == 2'(i) |-> $past(ent[i].sat) == $past(ent[i].fp))
         else $error("load completed partially satisfied");
      a_sc_early: assert property (@(posedge CLK) disable iff (!RSTN)
         CMD_VALID && CMD.op == OP_ALLOC && CMD.idx == 2'(i) && CMD.kind == K_ST && CMD.res && !CMD.pv
         |=> ent[i].scf && !ent[i].cm)
         else $error("unpaired conditional store not failed");
      a_commit_data: assert property (@(posedge CLK) disable iff (!RSTN)
         $rose(ent[i].cm) |-> $past(ent[i].dk) && $past(ent[i].fpk))
         else $error("store committed without data");
      a_store_done: assert property (@(posedge CLK) disable iff (!RSTN)
         COMP_VALID && COMP.is_st && COMP.ok && COMP.idx == 2'(i) |-> $past(ent[i].prop) == $past(ent[i].fp))
         else $error("store completed before propagation");
      a_sc_reserve: assert property (@(posedge CLK) disable iff (!RSTN)
         $rose(ent[i].cm) && ent[i].res |-> $past(ent[ent[i].pair].fin) && !$past(ent[ent[i].pair].lost))
         else $error("conditional store succeeded on lost reserve");
      a_sc_atomic: assert property (@(posedge CLK) disable iff (!RSTN)
         $rose(ent[i].cm) && ent[i].res |-> ent[i].prop == ent[i].fp && !ent[i].split)
         else $error("conditional store commit and propagate split");
      a_sc_late_fail: assert property (@(posedge CLK) disable iff (!RSTN)
         CMD_VALID && CMD.op == OP_SCFAIL && CMD.idx == 2'(i) && ent[i].kind == K_ST && ent[i].res &&
         ent[i].prop == 16'h0 && !sc_go[i] |=> ent[i].scf && ent[i].fp == 16'h0)
         else $error("late conditional store fail not applied");
      a_fail_result: assert property (@(posedge CLK) disable iff (!RSTN)
         COMP_VALID && COMP.is_st && COMP.idx == 2'(i) && $past(ent[i].scf) |-> !COMP.ok)
         else $error("failed conditional store reported success");
      a_store_foot: assert property (@(posedge CLK) disable iff (!RSTN)
         CMD_VALID && CMD.op == OP_FOOT && CMD.idx == 2'(i) && !ent[i].scf |=> ent[i].fpk && ent[i].fp != 16'h0)
         else $error("footprint not published");
      a_store_data: assert property (@(posedge CLK) disable iff (!RSTN)
         CMD_VALID && CMD.op == OP_DATA && CMD.idx == 2'(i) |=> ent[i].dk)
         else $error("store data not taken");
      for (genvar j = 0; j < i; j++) begin : g_old
         a_acq_order: assert property (@(posedge CLK) disable iff (!RSTN)
            sat_go[i] |-> !(ent[j].v && ent[j].kind == K_LD && ent[j].acq && !ent[j].fin &&
                            (ent[j].sat != ent[j].fp || !ent[j].fpk)))
            else $error("load passed unsatisfied acquire");
         a_commit_branch: assert property (@(posedge CLK) disable iff (!RSTN)
            $rose(ent[i].cm) |-> !$past(ent[j].v && !ent[j].fin && ent[j].brn))
            else $error("store committed past open branch");
         a_commit_fence: assert property (@(posedge CLK) disable iff (!RSTN)
            $rose(ent[i].cm) |-> !$past(ent[j].v && !ent[j].fin && (ent[j].fsw || ent[j].ftso)))
            else $error("store committed past open fence");
         a_restart_chain: assert property (@(posedge CLK) disable iff (!RSTN)
            next_restart[j] && ent[i].v && !ent[i].fin |=> RESTART[i])
            else $error("dependent not restarted");
         a_prop_order: assert property (@(posedge CLK) disable iff (!RSTN)
            ent[j].v && ent[j].kind == K_ST && !ent[j].scf |-> (pb[i] & ent[j].fp & ~ent[j].prop) == 16'h0)
            else $error("store propagated past older overlap");
         a_restart_hit: assert property (@(posedge CLK) disable iff (!RSTN)
            ent[i].v && !ent[i].fin && ent[i].kind == K_LD && (pb[j] & ent[i].sat) != 16'h0 |=> RESTART[i])
            else $error("stale load not restarted");
      end
   end
endmodule : hmou_top

// ---- testbench.sv ----
// Purpose: Self-checking bench for the hart memory ordering unit
// Assumes: Memory is zero after reset; entries are freed between scenarios
// Notes: Restart pulses are collected by a monitor so none is missed between waits
`timescale 1ns/100ps
module testbench import hmou_pkg::*; ();
   logic clk, rstn, cmd_valid, comp_valid, ext_req;
   hmou_cmd_s cmd, c;
   hmou_ext_s ext;
   hmou_comp_s comp;
   logic [NE-1:0] restart, seen_rs;
   logic [15:0] ext_mask;
   logic [127:0] ext_data;
   int fails, num_checks, cyc;

   hmou_top DUT (.CLK(clk), .RSTN(rstn), .CMD_VALID(cmd_valid), .CMD(cmd), .EXT(ext),
      .COMP_VALID(comp_valid), .COMP(comp), .RESTART(restart));
   hmou_hart_model HART (.clk(clk), .rstn(rstn), .req(ext_req), .mask(ext_mask), .data(ext_data), .ext(ext));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task end_sim;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   // Ceiling well above the few hundred cycles the scenarios need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (restart !== '0) seen_rs <= seen_rs | restart;
      if (cyc == 4000) begin
         fails = fails + 1;
         end_sim();
      end
   end

   task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   function automatic hmou_cmd_s mk(hmou_op_e op, int idx, logic [1:0] kind, int addr, int size, logic [63:0] d);
      mk = '0;
      mk.op = op;
      mk.idx = idx[1:0];
      mk.kind = kind;
      mk.addr = addr[3:0];
      mk.size = size[1:0];
      mk.data = d;
   endfunction : mk

   task send(input hmou_cmd_s t);
      cmd_valid <= 1'b1;
      cmd <= t;
      @(posedge clk);
   endtask : send

   // Footprint always goes out before data, as a real window would issue it
   task mem_op(input hmou_cmd_s t);
      hmou_cmd_s u;
      u = t;
      u.op = OP_ALLOC;
      send(u);
      u.op = OP_FOOT;
      send(u);
      if (t.kind == K_ST) begin
         u.op = OP_DATA;
         send(u);
      end
   endtask : mem_op

   task free_all;
      for (int i = 0; i < NE; i++) send(mk(OP_FREE, i, K_OTH, 0, 0, 0));
   endtask : free_all

   task wait_comp(input string name, input int idx, input logic st, input logic ok, input logic [63:0] d);
      int n;
      n = 0;
      cmd_valid <= 1'b0;
      do begin
         // Read at the edge: the value that stood through the cycle just ended
         @(posedge clk);
         n++;
      end while (comp_valid !== 1'b1 && n < 40);
      chk({name, " valid"}, 64'h1, {63'h0, comp_valid});
      chk({name, " tag"}, {idx[1:0], st, st & ok}, {comp.idx, comp.is_st, st & comp.ok});
      if (!st) chk({name, " data"}, d, comp.data);
   endtask : wait_comp

   task no_comp(input string name, input int n);
      int hits;
      hits = 0;
      cmd_valid <= 1'b0;
      repeat (n) begin
         @(posedge clk);
         if (comp_valid !== 1'b0) hits++;
      end
      chk(name, 0, hits);
   endtask : no_comp

   task t_store_load;
      mem_op(mk(OP_NOP, 0, K_ST, 0, 2, 64'h44332211));
      wait_comp("aligned store", 0, 1, 1, 0);
      free_all();
      mem_op(mk(OP_NOP, 0, K_ST, 1, 1, 64'hbbaa));
      wait_comp("split store", 0, 1, 1, 0);
      free_all();
      mem_op(mk(OP_NOP, 0, K_LD, 0, 2, 0));
      wait_comp("load word", 0, 0, 0, 64'h44bbaa11);
      free_all();
   endtask : t_store_load

   task t_sc;
      c = mk(OP_ALLOC, 0, K_ST, 4, 2, 0);
      c.res = 1'b1;
      send(c);
      wait_comp("unpaired sc", 0, 1, 0, 0);
      free_all();
      for (int lost = 0; lost < 2; lost++) begin
         c = mk(OP_NOP, 0, K_LD, 4, 2, 0);
         c.res = 1'b1;
         mem_op(c);
         wait_comp("reserve load", 0, 0, 0, lost ? 64'h55667788 : 64'h0);
         if (lost) begin
            ext_mask <= 16'h00f0;
            ext_data <= 128'h0f0e0d0c << 32;
            ext_req <= 1'b1;
            @(posedge clk);
            ext_req <= 1'b0;
         end
         send(mk(OP_FINISH, 0, K_LD, 4, 2, 0));
         c = mk(OP_NOP, 1, K_ST, 4, 2, 64'h55667788);
         c.res = 1'b1;
         c.pv = 1'b1;
         mem_op(c);
         if (lost) begin
            no_comp("sc on lost reserve", 6);
            send(mk(OP_SCFAIL, 1, K_ST, 4, 2, 0));
         end
         wait_comp("paired sc", 1, 1, lost == 0, 0);
         free_all();
      end
      mem_op(mk(OP_NOP, 0, K_LD, 4, 2, 0));
      wait_comp("after lost sc", 0, 0, 0, 64'h0f0e0d0c);
      free_all();
   endtask : t_sc

   // Younger load waits while an older acquire load has no footprint yet
   task t_acq;
      c = mk(OP_ALLOC, 0, K_LD, 4, 0, 0);
      c.acq = 1'b1;
      send(c);
      mem_op(mk(OP_NOP, 1, K_LD, 0, 0, 0));
      no_comp("load behind acquire", 8);
      send(mk(OP_FOOT, 0, K_LD, 4, 0, 0));
      wait_comp("acquire load", 0, 0, 0, 64'h0c);
      wait_comp("load after acquire", 1, 0, 0, 64'h11);
      free_all();
   endtask : t_acq

   // Older branch, write fence, store-order fence, then a release store behind a plain op
   task t_order;
      for (int k = 0; k < 4; k++) begin
         c = mk(OP_ALLOC, 0, K_OTH, 0, 0, 0);
         c.brn = (k == 0);
         c.fsw = (k == 1);
         c.ftso = (k == 2);
         send(c);
         c = mk(OP_NOP, 1, K_ST, 12, 0, k);
         c.rel = (k == 3);
         mem_op(c);
         no_comp("store held", 10);
         send(mk(OP_FINISH, 0, K_OTH, 0, 0, 0));
         wait_comp("store released", 1, 1, 1, 0);
         free_all();
      end
   endtask : t_order

   task t_restart;
      c = mk(OP_ALLOC, 0, K_ST, 8, 0, 64'h99);
      send(c);
      c.op = OP_FOOT;
      send(c);
      mem_op(mk(OP_NOP, 1, K_LD, 8, 0, 0));
      wait_comp("early load", 1, 0, 0, 0);
      seen_rs = '0;
      c.op = OP_DATA;
      send(c);
      wait_comp("older store", 0, 1, 1, 0);
      chk("restart mask", 4'h2, seen_rs);
      free_all();
   endtask : t_restart

   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      ext_req = 1'b0;
      ext_mask = '0;
      ext_data = '0;
      fails = 0;
      num_checks = 0;
      cyc = 0;
      seen_rs = '0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk("reset outputs", 0, {comp_valid, restart});
      t_store_load();
      t_sc();
      t_acq();
      t_order();
      t_restart();
      end_sim();
   end
endmodule : testbench
